/* File: design/lp_ctrl.sv */
// Purpose: power-down, idle, slow idle, clock output and master reset control
// Assumes: only the power-down and emulator reset pins are synchronised here; processor core sits outside
// Notes: classic wishbone slave, one wait state
//
// Summary of operation
// RL1 - clock kept running: resume execution 200 input cycles after power-down exit
// RL2 - oscillator stopped: wait about 4096 input cycles before resuming
// RL3 - power-down requested by pin or software force bit
// RL4 - request raises nonmaskable edge interrupt; handler later commits to power-down
// RL5 - context setting chooses resume from saved state or cleared restart
// RL6 - reset ends power-down
// RL7 - acknowledge output shows power-down actually entered
// RL8 - idle stalls until unmasked interrupt, then continues after idle
// RL9 - dma and autobuffer cycle steals still granted while idle
// RL10 - slow idle divides processor clock by 16, 32, 64 or 128
// RL11 - serial clock, clock output and timer clock divided by same ratio
// RL12 - idle without divisor is plain idle, one-cycle response
// RL13 - interrupt in slow idle may wait up to divisor cycles
// RL14 - outside sources must not interrupt faster than slowed device serves
// RL15 - input clock only stops or changes while powered down
// RL16 - processor cycle is twice input clock rate; here the processor tick comes every other input cycle
// RL17 - clock output runs at cycle rate unless disable bit set; here it toggles once per processor tick, so runs at half that rate
// RL18 - at power-up reset held 2000 cycles for pll lock
// RL19 - later reset keeps clock running, no stabilisation wait
// RL20 - reset empties stacks, masks interrupts, clears mode status
// RL21 - on release, no bus request and boot set: boot then fetch 0x0000
// RL22 - emulator reset acts like reset
// RL23 - power-down interrupt ignores the mask
// RL24 - interrupts globally enabled after reset
// RL25 - slow divider returns to one on idle exit and reset
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module lp_ctrl (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic clk_en_in,
   input wire lp_ctrl_pkg::wb_req_t wb_req_in,
   output lp_ctrl_pkg::wb_rsp_t wb_rsp_out,
   input wire logic powerdown_request_pin_n_in,
   input wire logic emulator_reset_pin_n_in,
   input wire logic [7:0] irq_in,
   input wire logic idle_cmd_in,
   input wire logic [2:0] idle_div_in,
   input wire logic steal_req_in,
   input wire logic bus_request_in,
   input wire logic boot_done_in,
   output logic steal_grant_out,
   output logic proc_tick_out,
   output logic clock_output_pin_out,
   output logic powerdown_ack_out,
   output logic osc_enable_out,
   output logic run_out,
   output logic stack_clear_out,
   output logic ctx_clear_out,
   output logic nmi_out,
   output logic [7:0] irq_taken_out,
   output logic boot_start_out,
   output logic [13:0] fetch_addr_out
);
   import lp_ctrl_pkg::*;
   lp_state_t s;
   lp_state_t next_s;
   logic pd_s1, pd_s2, er_s1, er_s2;
   logic rst_any;
   logic bus_acc;
   logic [7:0] pending;
   logic tick;
   logic [6:0] div_mask;

   // pin synchronisers, first stage read only by second
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         pd_s1 <= 1'b1;
         pd_s2 <= 1'b1;
         er_s1 <= 1'b1;
         er_s2 <= 1'b1;
      end else if (clk_en_in) begin
         pd_s1 <= powerdown_request_pin_n_in;
         pd_s2 <= pd_s1;
         er_s1 <= emulator_reset_pin_n_in;
         er_s2 <= er_s1;
      end
   end

   // RL22 emulator reset alias
   assign rst_any = !reset_n_in || !er_s2;
   assign bus_acc = wb_req_in.cyc && wb_req_in.stb && !s.ack;
   // RL23 power-down not masked
   assign pending = irq_in & s.imask;

   always_comb begin
      case (s.div)
         DIV_16: div_mask = 7'h0F;
         DIV_32: div_mask = 7'h1F;
         DIV_64: div_mask = 7'h3F;
         DIV_128: div_mask = 7'h7F;
         default: div_mask = 7'h00;
      endcase
   end
   // RL16 processor tick every other input cycle
   // RL10 slow idle prescaler gates the tick
   assign tick = s.half && ((s.prescale & div_mask) == 7'h00);

   always_comb begin
      next_s = s;
      next_s.ack = 1'b0;
      next_s.pd_nmi = 1'b0;
      next_s.half = !s.half;
      if (s.half) begin
         next_s.prescale = s.prescale + 7'h01;
      end
      // RL17 clock output toggles on processor cycle
      // RL11 same divided tick drives derived clocks
      if (tick && !s.ctrl[CLKO_DIS_BIT] && s.st != ST_PD) begin
         next_s.clk_out = !s.clk_out;
      end else if (s.ctrl[CLKO_DIS_BIT]) begin
         next_s.clk_out = 1'b0;
      end
      if (s.pd_pending && s.ctrl[INT_ENA_BIT] && s.st == ST_RUN) begin
         next_s.pd_nmi = 1'b1;
         next_s.pd_pending = 1'b0;
      end
      // RL3 pin edge or force bit requests power-down
      // RL4 edge captured as nonmaskable event
      // placed after the consume so a fresh edge is never lost
      next_s.pd_pin_q = pd_s2;
      if ((s.pd_pin_q && !pd_s2) || s.ctrl[FORCE_BIT]) begin
         next_s.pd_pending = 1'b1;
         next_s.ctrl[FORCE_BIT] = 1'b0;
      end
      // register writes; hardware set of pending wins above
      if (bus_acc) begin
         next_s.ack = 1'b1;
         next_s.rdat = 32'h0000_0000;
         case (wb_req_in.adr)
            CTRL_OFS: begin
               next_s.rdat = {24'h000000, s.ctrl};
               if (wb_req_in.we && wb_req_in.sel[0]) begin
                  // force bit raises pending next cycle, one event only
                  next_s.ctrl = wb_req_in.dat[7:0];
               end
            end
            IDLE_OFS: begin
               next_s.rdat = {21'h000000, s.div, s.imask};
               if (wb_req_in.we && wb_req_in.sel[0]) begin
                  next_s.imask = wb_req_in.dat[7:0];
               end
            end
            STAT_OFS: begin
               next_s.rdat = {24'h000000, s.pd_pending, 1'b0, s.ctx_clear,
                  2'b00, s.st};
            end
            MODE_OFS: begin
               next_s.rdat = {16'h0000, s.mode_status};
               if (wb_req_in.we && wb_req_in.sel[0]) begin
                  next_s.mode_status[7:0] = wb_req_in.dat[7:0];
               end
               if (wb_req_in.we && wb_req_in.sel[1]) begin
                  next_s.mode_status[15:8] = wb_req_in.dat[15:8];
               end
            end
            default: next_s.rdat = 32'h0000_0000;
         endcase
      end
      case (s.st)
         ST_RUN: begin
            // RL4 handler commits after any number of instructions
            if (s.ctrl[COMMIT_BIT]) begin
               next_s.st = ST_PD;
               next_s.ctrl[COMMIT_BIT] = 1'b0;
            end else if (idle_cmd_in) begin
               // RL12 no divisor gives plain idle
               next_s.st = ST_IDLE;
               next_s.div = idle_div_in;
               next_s.prescale = 7'h00;
            end
         end
         ST_IDLE: begin
            // RL8 leave on unmasked interrupt
            // RL13 only on divided tick, up to n cycles
            if ((|pending || s.pd_pending) && tick) begin
               next_s.st = ST_RUN;
               // RL25 back to full rate
               next_s.div = DIV_NONE;
            end
         end
         ST_PD: begin
            // RL15 clock may stop here; wake on pin release with no request pending
            if (pd_s2 && !s.pd_pending) begin
               next_s.st = ST_WAKE;
               // RL1 short recovery, RL2 long when oscillator stopped
               next_s.cnt = s.ctrl[OSC_OFF_BIT] ? OSC_WAIT_CNT : RECOVER_CNT;
               // RL5 context choice
               next_s.ctx_clear = !s.ctrl[CTX_SAVE_BIT];
            end
         end
         ST_WAKE: begin
            if (s.cnt <= CNT_W'(1)) begin
               next_s.st = ST_RUN;
            end else begin
               next_s.cnt = s.cnt - CNT_W'(1);
            end
         end
         ST_BOOT: begin
            if (boot_done_in) begin
               next_s.st = ST_RUN;
            end
         end
         default: next_s.st = ST_RUN;
      endcase
   end

   always_ff @(posedge clk_in) begin
      // RL6 reset ends power-down; RL19 no wait after it
      if (rst_any) begin
         s.st <= ST_BOOT;
         s.ctrl <= CTRL_RESET;
         // RL25 divider to one
         s.div <= DIV_NONE;
         // RL20 mask all, clear mode status
         s.imask <= IMASK_RESET;
         s.mode_status <= 16'h0000;
         s.cnt <= '0;
         s.prescale <= 7'h00;
         s.half <= 1'b0;
         s.clk_out <= 1'b0;
         s.pd_pin_q <= 1'b1;
         s.pd_pending <= 1'b0;
         s.pd_nmi <= 1'b0;
         s.ctx_clear <= 1'b1;
         s.ack <= 1'b0;
         s.rdat <= 32'h0000_0000;
      end else if (clk_en_in) begin
         s <= next_s;
      end
   end

   // RL18 reset length is the supply side's duty; nothing timed here
   assign wb_rsp_out.ack = s.ack;
   assign wb_rsp_out.dat = s.rdat;
   // RL9 steals granted in run and idle
   assign steal_grant_out = steal_req_in && (s.st == ST_RUN || s.st == ST_IDLE);
   assign proc_tick_out = tick && (s.st != ST_PD);
   assign clock_output_pin_out = s.clk_out;
   // RL7 acknowledge from state
   assign powerdown_ack_out = (s.st == ST_PD);
   assign osc_enable_out = !(s.st == ST_PD && s.ctrl[OSC_OFF_BIT]);
   assign run_out = (s.st == ST_RUN);
   // RL20 stacks emptied during reset
   assign stack_clear_out = rst_any;
   assign ctx_clear_out = s.ctx_clear;
   assign nmi_out = s.pd_nmi;
   // RL24 global enable gates maskable interrupts
   assign irq_taken_out = s.ctrl[INT_ENA_BIT] ? pending : 8'h00;
   // RL21 boot only if configured and no bus request
   assign boot_start_out = (s.st == ST_BOOT) && s.ctrl[BOOT_CFG_BIT] && !bus_request_in;
   assign fetch_addr_out = BOOT_FETCH_ADDR;
endmodule

/* File: inc/lp_ctrl_pkg.sv */
// Purpose: shared constants and carriers for the low-power clock/reset control
// Assumes: 125 MHz system clock
// Notes: register offsets are word aligned byte addresses
package lp_ctrl_pkg;
   localparam int CLK_MHZ = 125;
   // recovery and oscillator waits, in input-clock cycles
   localparam int RECOVER_CYCLES = 200;
   localparam int OSC_WAIT_CYCLES = 4096;
   localparam int CNT_W = 13;
   localparam logic [CNT_W-1:0] RECOVER_CNT = CNT_W'(RECOVER_CYCLES);
   localparam logic [CNT_W-1:0] OSC_WAIT_CNT = CNT_W'(OSC_WAIT_CYCLES);
   localparam logic [13:0] BOOT_FETCH_ADDR = 14'h0000;
   // register byte offsets
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] IDLE_OFS = 4'h4;
   localparam logic [3:0] STAT_OFS = 4'h8;
   localparam logic [3:0] MODE_OFS = 4'hC;
   // control bit positions
   localparam int FORCE_BIT = 0;
   localparam int CTX_SAVE_BIT = 1;
   localparam int OSC_OFF_BIT = 2;
   localparam int COMMIT_BIT = 3;
   localparam int CLKO_DIS_BIT = 4;
   localparam int INT_ENA_BIT = 5;
   localparam int BOOT_CFG_BIT = 6;
   localparam logic [7:0] CTRL_RESET = 8'h20;
   localparam logic [2:0] DIV_NONE = 3'h0;
   localparam logic [2:0] DIV_16 = 3'h1;
   localparam logic [2:0] DIV_32 = 3'h2;
   localparam logic [2:0] DIV_64 = 3'h3;
   localparam logic [2:0] DIV_128 = 3'h4;
   localparam logic [7:0] IMASK_RESET = 8'h00;
   typedef enum logic [2:0] {ST_RUN, ST_IDLE, ST_PD, ST_WAKE, ST_BOOT} pstate_t;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_t;
   typedef struct packed {
      pstate_t st;
      logic [7:0] ctrl;
      logic [2:0] div;
      logic [7:0] imask;
      logic [15:0] mode_status;
      logic [CNT_W-1:0] cnt;
      logic [6:0] prescale;
      logic half;
      logic clk_out;
      logic pd_pin_q;
      logic pd_pending;
      logic pd_nmi;
      logic ctx_clear;
      logic ack;
      logic [31:0] rdat;
   } lp_state_t;
endpackage

/* File: verif/lp_ctrl_chk.sv */
// Purpose: port checks for lp_ctrl
// Assumes: clk_en_in held high
// Notes: bound at the foot
`timescale 1ns/1ps
module lp_ctrl_chk (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic clk_en_in,
   input wire lp_ctrl_pkg::wb_req_t wb_req_in,
   input wire lp_ctrl_pkg::wb_rsp_t wb_rsp_out,
   input wire logic steal_req_in,
   input wire logic steal_grant_out,
   input wire logic proc_tick_out,
   input wire logic clock_output_pin_out,
   input wire logic powerdown_ack_out,
   input wire logic osc_enable_out,
   input wire logic run_out,
   input wire logic stack_clear_out,
   input wire logic nmi_out,
   input wire logic [7:0] irq_in,
   input wire logic [7:0] irq_taken_out,
   input wire logic [13:0] fetch_addr_out
);
   import lp_ctrl_pkg::*;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence take_s;
      wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack && clk_en_in;
   endsequence
   sequence answer_s;
      wb_rsp_out.ack ##1 !wb_rsp_out.ack;
   endsequence
   bus_ack_a: assert property (take_s |=> answer_s)
      else $error("bad ack timing");
   tick_pulse_a: assert property (proc_tick_out |=> !proc_tick_out)
      else $error("tick too long");
   clko_rise_a: assert property ($rose(clock_output_pin_out) |-> $past(proc_tick_out))
      else $error("clock out rose without tick");
   osc_off_a: assert property (!osc_enable_out |-> powerdown_ack_out)
      else $error("oscillator off outside power-down");
   steal_run_a: assert property (run_out && steal_req_in |-> steal_grant_out)
      else $error("steal not granted");
   steal_pd_a: assert property (steal_grant_out |-> steal_req_in && !powerdown_ack_out)
      else $error("steal granted wrongly");
   nmi_pulse_a: assert property (nmi_out |=> !nmi_out)
      else $error("nmi not a pulse");
   irq_taken_a: assert property ((irq_taken_out & ~irq_in) == 8'h00)
      else $error("irq taken without request");
   boot_addr_a: assert property (fetch_addr_out == BOOT_FETCH_ADDR)
      else $error("fetch address not zero");
   rst_stack_a: assert property (disable iff (1'b0) !reset_n_in |-> stack_clear_out)
      else $error("stacks kept in reset");
   rst_pd_a: assert property (disable iff (1'b0) !reset_n_in |=> !powerdown_ack_out)
      else $error("power-down survived reset");
endmodule
bind lp_ctrl lp_ctrl_chk lp_ctrl_chk_i (.clk_in, .reset_n_in, .clk_en_in, .wb_req_in,
   .wb_rsp_out, .steal_req_in, .steal_grant_out, .proc_tick_out, .clock_output_pin_out,
   .powerdown_ack_out, .osc_enable_out, .run_out, .stack_clear_out, .nmi_out, .irq_in,
   .irq_taken_out, .fetch_addr_out);

/* File: verif/lp_far_end.sv */
// Purpose: reset and power-down driving logic
// Assumes: clock never stops
// Notes: pins change only after an edge
`timescale 1ns/1ps
module lp_far_end (
   input wire logic clk_in,
   input wire logic pd_cmd_in,
   input wire logic erst_cmd_in,
   output logic powerdown_request_pin_n_out = 1'b1,
   output logic emulator_reset_pin_n_out = 1'b0
);
   int age = 0;
   always @(posedge clk_in) begin
      age <= age + 1;
      emulator_reset_pin_n_out <= (age >= 2000) && !erst_cmd_in;
      powerdown_request_pin_n_out <= !pd_cmd_in;
   end
endmodule

/* File: verif/testbench.sv */
// Purpose: self-checking bench for lp_ctrl
// Assumes: clk_en_in held high
// Notes: reads queued, compared on ack
`timescale 1ns/1ps
module testbench;
   import lp_ctrl_pkg::*;
   logic clk_in = 1'b0, reset_n_in = 1'b0, clk_en_in = 1'b1, pd_cmd = 1'b0, erst_cmd = 1'b0;
   logic idle_cmd = 1'b0, steal = 1'b0, bus_req = 1'b0, boot_done = 1'b0, pd_n, erst_n;
   logic grant, tick, clko, pd_ack, osc_en, run, stk, nmi, ctx, boot;
   logic [7:0] irq = 8'h00, taken;
   logic [2:0] div = 3'h0;
   logic [13:0] fetch;
   logic [31:0] lfsr = 32'h1C7CF39F, v;
   logic [31:0] exp_q[$];
   wb_req_t req = '0;
   wb_rsp_t rsp;
   int fail_count = 0, comparisons = 0, cycles = 0, n, gap = 0, nmi_n = 0;
   always #4 clk_in = ~clk_in;
   lp_far_end lp_far_end_i (.clk_in, .pd_cmd_in(pd_cmd), .erst_cmd_in(erst_cmd),
      .powerdown_request_pin_n_out(pd_n), .emulator_reset_pin_n_out(erst_n));
   lp_ctrl lp_ctrl_i (.clk_in, .reset_n_in, .clk_en_in, .wb_req_in(req), .wb_rsp_out(rsp),
      .powerdown_request_pin_n_in(pd_n), .emulator_reset_pin_n_in(erst_n), .irq_in(irq),
      .idle_cmd_in(idle_cmd), .idle_div_in(div), .steal_req_in(steal),
      .bus_request_in(bus_req), .boot_done_in(boot_done), .steal_grant_out(grant),
      .proc_tick_out(tick), .clock_output_pin_out(clko), .powerdown_ack_out(pd_ack),
      .osc_enable_out(osc_en), .run_out(run), .stack_clear_out(stk), .ctx_clear_out(ctx),
      .nmi_out(nmi), .irq_taken_out(taken), .boot_start_out(boot), .fetch_addr_out(fetch));
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      comparisons++;
      if (got !== want) begin
         fail_count++;
         $display("[ERR] %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tk(input int k);
      repeat (k) @(posedge clk_in);
   endtask
   task automatic wait_for(ref logic s, input logic lvl);
      while (s !== lvl) tk(1);
   endtask
   // held until ack is sampled, then one idle cycle
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, want);
      if (!w) exp_q.push_back(want);
      req <= '{1'b1, 1'b1, w, a, 4'hF, d};
      do tk(1); while (rsp.ack !== 1'b1);
      req <= '0;
      tk(1);
   endtask
   task automatic boot_go();
      boot_done <= 1'b1;
      tk(1);
      boot_done <= 1'b0;
      tk(1);
   endtask
   always @(posedge clk_in) begin
      cycles++;
      lfsr <= nx(lfsr);
      steal <= lfsr[3];
      bus_req <= lfsr[7];
      if (nmi) nmi_n++;
      if (pd_ack) gap <= 0;
      else if (!run) gap <= gap + 1;
      if (rsp.ack && !req.we && exp_q.size() > 0) check(rsp.dat, exp_q.pop_front());
      if (cycles == 20000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      tk(10);
      reset_n_in <= 1'b1;
      wait_for(erst_n, 1'b1);
      tk(5);
      wb(0, CTRL_OFS, 0, {24'h0, CTRL_RESET});
      wb(0, IDLE_OFS, 0, 32'h0);
      wb(0, STAT_OFS, 0, 32'h24);
      wb(1, CTRL_OFS, 32'h60, 0);
      check(boot, 32'(!bus_req));
      boot_go();
      v = lfsr;
      wb(1, MODE_OFS, v, 0);
      wb(0, MODE_OFS, 0, {16'h0, v[15:0]});
      wb(1, 4'h2, v, 0);
      wb(0, 4'h2, 0, 32'h0);
      reset_n_in <= 1'b0;
      tk(2);
      reset_n_in <= 1'b1;
      tk(1);
      boot_go();
      wb(0, MODE_OFS, 0, 32'h0);
      wb(1, CTRL_OFS, 32'h30, 0);
      tk(8);
      check(clko, 32'h0);
      wb(1, CTRL_OFS, 32'h21, 0);
      wb(1, CTRL_OFS, 32'h28, 0);
      tk(2);
      wait_for(run, 1'b1);
      check(32'(gap >= 200 && gap <= 202), 32'h1);
      check(ctx, 32'h1);
      pd_cmd <= 1'b1;
      tk(8);
      wb(1, CTRL_OFS, 32'h2E, 0);
      tk(20);
      check({pd_ack, osc_en}, 32'h2);
      pd_cmd <= 1'b0;
      tk(4);
      wait_for(run, 1'b1);
      check(32'(gap >= 4096 && gap <= 4098), 32'h1);
      check(ctx, 32'h0);
      check(nmi_n, 32'h2);
      wb(1, CTRL_OFS, 32'h20, 0);
      pd_cmd <= 1'b1;
      tk(8);
      wb(1, CTRL_OFS, 32'h28, 0);
      tk(4);
      check(pd_ack, 32'h1);
      erst_cmd <= 1'b1;
      tk(6);
      check({pd_ack, stk}, 32'h1);
      erst_cmd <= 1'b0;
      pd_cmd <= 1'b0;
      tk(6);
      boot_go();
      wb(1, IDLE_OFS, 32'h1, 0);
      for (int i = 0; i < 5; i++) begin
         div <= i[2:0];
         idle_cmd <= 1'b1;
         tk(1);
         idle_cmd <= 1'b0;
         tk(3);
         wait_for(tick, 1'b1);
         n = 0;
         do begin
            tk(1);
            n++;
         end while (tick !== 1'b1);
         check(n, (i == 0) ? 32'h2 : 32'h20 << (i - 1));
         check(run, 32'h0);
         irq <= 8'h01;
         tk(n + 4);
         check(run, 32'h1);
         irq <= 8'h00;
         wb(0, IDLE_OFS, 0, 32'h1);
      end
      close_out();
   end
endmodule
